// *** hw/power_save_defs.svh ***
/*
  Constants of the power-save mode controller: register offsets, field
  positions, reset values and timing counts. Assumes a 50 MHz sys_clk and
  an instruction-cycle strobe from the CPU.
*/
//
// Contract
// - retention regulator on only in Sleep, fuse at zero and enable bit set
// - Idle halts CPU, clears watchdog, keeps system clock and peripherals
// - Idle ends on enabled interrupt, any reset or watchdog time-out
// - Idle wake gives the CPU its clock back at once
// - Sleep stops clock, oscillator, monitor, clocked peripherals; pins freeze
// - low-power RC oscillator runs in Sleep if watchdog or its calendar needs it
// - enabled watchdog is cleared just before Sleep entry
// - Sleep wake triggers as Idle; restart on the clock source used at entry
// - retention Sleep wakes alike but waits the regulator settle time
// - Deep Sleep stops clock, freezes pins, keeps only deep watchdog, brown-out, calendar
// - Deep Sleep exits on power-on, deep watchdog, enabled alarm, master clear low
// - interrupt 0 wakes Deep Sleep if armed, at its polarity, after a pin change
// - Deep Sleep enable lapses unless power-save instruction follows in time
// - Deep Sleep enable clears on Deep Sleep exit
// - protected registers change only on a doubled write
// - setting Deep Sleep enable clears the wake-source register
// - pending interrupts are discarded at Deep Sleep entry
// - Deep Sleep exit is a power-on reset; scratch and watchdog state kept
// - wake sources recorded from enable set until release cleared
// - after exit, core restarts at reset vector, exit flag set until cleared
// - brown-out flag bit 1, release bit 0 of the control register
// - pins stay frozen after wake until release bit is cleared
// - deep watchdog counter reset on every Deep Sleep entry
`ifndef POWER_SAVE_DEFS_SVH
`define POWER_SAVE_DEFS_SVH

`define ADDR_W            8
`define DATA_W            16
`define OFF_DS_CONTROL    8'h00
`define OFF_WAKE_SOURCE   8'h04
`define OFF_SCRATCH_0     8'h08
`define OFF_SCRATCH_1     8'h0C
`define OFF_RESET_CONTROL 8'h10
`define OFF_STATUS        8'h14

`define BIT_DS_ENABLE     15
`define BIT_DS_BROWNOUT   1
`define BIT_DS_RELEASE    0
`define BIT_RETENTION_EN  12
`define BIT_DS_EXIT_FLAG  10

`define RESET_VAL_16      16'h0000
`define PIN_RESET_VAL     6'h01

`define CLK_PERIOD_NS     20
`define REG_SETTLE_NS     10000
`define REG_SETTLE_CYC    ((`REG_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DS_ENTRY_TCY      4
`define DS_REENTRY_TCY    3
`define DS_EXIT_RST_CYC   16

`endif

// *** hw/power_save_pkg.sv ***
/*
  Types shared by the power-save mode controller and its bench.
  Assumes nothing beyond a SystemVerilog package scope.
*/
package power_save_pkg;

  typedef enum logic [2:0] {
    ST_RUN    = 3'b000,
    ST_IDLE   = 3'b001,
    ST_SLEEP  = 3'b010,
    ST_SETTLE = 3'b011,
    ST_DEEP   = 3'b100,
    ST_EXIT   = 3'b101
  } pwr_state_e;

  // bit order matches the wake-source register, mclear in bit 0
  typedef struct packed {
    logic brownout;
    logic por;
    logic int0;
    logic dwdt;
    logic alarm;
    logic mclear;
  } wake_evt_s;

  typedef struct packed {
    logic low_power_config_fuse;
    logic wdt_enable;
    logic cmon_enable;
    logic calendar_clock_enable;
    logic calendar_on_lposc;
    logic int0_enable;
    logic int0_polarity;
  } pwr_cfg_s;

  typedef struct packed {
    logic cpu_clk_en;
    logic sys_clk_en;
    logic osc_en;
    logic lposc_en;
    logic cmon_en;
    logic periph_sysclk_en;
    logic pins_frozen;
    logic retention_reg_en;
  } clk_ctrl_s;

  typedef struct packed {
    logic wdt_clear;
    logic dwdt_reset;
    logic irq_discard;
    logic core_reset;
  } pwr_pulse_s;

endpackage

// *** hw/power_save_mode_controller.sv ***
/*
  Power-save mode controller: Idle, Sleep, retention Sleep and Deep Sleep
  sequencing, protected Deep Sleep registers and wake-source capture.
  Assumes the CPU pulses instr_cycle once per instruction, issues the
  power-save instruction as a one-cycle pulse, and that rst_n is the true
  power-on reset of the Deep Sleep logic.
*/
`include "power_save_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module power_save_mode_controller #(
  parameter int SETTLE_CYC = `REG_SETTLE_CYC,
  parameter int EXIT_CYC   = `DS_EXIT_RST_CYC
) (
  input  wire logic                     sys_clk,       // 50 MHz clock
  input  wire logic                     rst_n,         // sync reset, low
  input  wire logic [`ADDR_W-1:0]       addr,          // register address
  input  wire logic [`DATA_W-1:0]       wdata,         // write data
  input  wire logic                     wr,            // write strobe
  input  wire logic                     rd,            // read strobe
  output logic [`DATA_W-1:0]            rdata,         // read data, next cycle
  input  wire logic                     instr_cycle,   // one per instruction
  input  wire logic                     psave_valid,   // power-save instr
  input  wire logic                     psave_idle,    // 1 idle, 0 sleep
  input  wire logic [1:0]               clk_src,       // active clock source
  input  wire power_save_pkg::pwr_cfg_s cfg,           // fuses and enables
  input  wire logic                     irq_wake,      // enabled irq pending
  input  wire logic                     reset_req,     // any device reset
  input  wire logic                     wdt_timeout,   // watchdog time-out
  input  wire logic                     ext_int0,      // interrupt 0 pin
  input  wire logic                     master_clear_pin_n, // pin, low
  input  wire logic                     por_event,     // supply power-on
  input  wire logic                     brownout_event,// deep brown-out
  input  wire logic                     dwdt_timeout,  // deep watchdog
  input  wire logic                     calendar_alarm,// calendar alarm
  output power_save_pkg::clk_ctrl_s     clk_ctrl,      // gating, registered
  output power_save_pkg::pwr_pulse_s    pulses,        // one-cycle pulses, core_reset held in exit
  output logic [1:0]                    resume_clk_src,// source to restart
  output power_save_pkg::pwr_state_e    state          // current mode
);
  import power_save_pkg::*;

  // refuse counts that the 16-bit step counter cannot reach
  if (SETTLE_CYC < 1 || SETTLE_CYC > 65535 || EXIT_CYC < 1 ||
      EXIT_CYC > 65535) begin : g_bad_count
    $error("power_save_mode_controller: count parameter out of range");
  end

  localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_CYC - 1);
  localparam logic [15:0] EXIT_LAST   = 16'(EXIT_CYC - 1);
  localparam logic [2:0]  ENTRY_LAST  = 3'(`DS_ENTRY_TCY - 1);
  localparam logic [1:0]  REENTRY     = 2'(`DS_REENTRY_TCY);

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, accept when stages two and three agree

  logic [5:0] pin_raw;
  logic [5:0] s1_q, s2_q, s3_q, pin_q;
  logic [5:0] s1_d, s2_d, s3_d, pin_d;

  assign pin_raw = {brownout_event, por_event, ext_int0, dwdt_timeout,
                    calendar_alarm, master_clear_pin_n};

  always_comb begin
    s1_d  = pin_raw;
    s2_d  = s1_q;
    s3_d  = s2_q;
    pin_d = pin_q;
    for (int i = 0; i < 6; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        pin_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s1_q  <= `PIN_RESET_VAL;
      s2_q  <= `PIN_RESET_VAL;
      s3_q  <= `PIN_RESET_VAL;
      pin_q <= `PIN_RESET_VAL;
    end else begin
      s1_q  <= s1_d;
      s2_q  <= s2_d;
      s3_q  <= s3_d;
      pin_q <= pin_d;
    end
  end

  logic mclear_low, alarm_f, dwdt_f, int0_f, por_f, bor_f;
  assign mclear_low = ~pin_q[0];
  assign alarm_f  = pin_q[1];
  assign dwdt_f   = pin_q[2];
  assign int0_f   = pin_q[3];
  assign por_f    = pin_q[4];
  assign bor_f    = pin_q[5];

  //////////////////////////////////////////////////////////////////////////
  // registers and sequencer state

  pwr_state_e         state_q, state_d;
  logic               ds_en_q, ds_en_d;
  logic               release_q, release_d;
  logic               bor_flag_q, bor_flag_d;
  logic               exit_flag_q, exit_flag_d;
  logic               ret_en_q, ret_en_d;
  wake_evt_s          wake_q, wake_d;
  logic [`DATA_W-1:0] scratch0_q, scratch0_d;
  logic [`DATA_W-1:0] scratch1_q, scratch1_d;
  logic               pend_q, pend_d;
  logic [`ADDR_W-1:0] pend_addr_q, pend_addr_d;
  logic [`DATA_W-1:0] pend_data_q, pend_data_d;
  logic [2:0]         win_q, win_d;
  logic [1:0]         hold_q, hold_d;
  logic [15:0]        cnt_q, cnt_d;
  logic               settle_q, settle_d;
  logic               int0_arm_q, int0_arm_d;
  logic               int0_ref_q, int0_ref_d;
  logic [1:0]         src_q, src_d;
  clk_ctrl_s          ctl_q, ctl_d;
  pwr_pulse_s         pul_q, pul_d;
  logic [`DATA_W-1:0] rdata_q, rdata_d;

  logic      prot_hit, commit, deep_go, wake_any, ds_wake, int0_wake;
  wake_evt_s events;

  // a doubled write is two consecutive bus writes of equal address and data
  assign prot_hit = wr && (addr == `OFF_DS_CONTROL ||
                           addr == `OFF_WAKE_SOURCE ||
                           addr == `OFF_SCRATCH_0 ||
                           addr == `OFF_SCRATCH_1);
  assign commit   = prot_hit && pend_q && pend_addr_q == addr &&
                    pend_data_q == wdata;
  assign deep_go  = state_q == ST_RUN && psave_valid && !psave_idle &&
                    ds_en_q;
  assign wake_any = irq_wake || reset_req || wdt_timeout;
  // pin must have moved away from its entry level and sit at the polarity
  assign int0_wake = int0_arm_q && int0_f == cfg.int0_polarity &&
                     int0_f != int0_ref_q;

  always_comb begin
    events          = '0;
    events.mclear   = mclear_low;
    events.alarm    = alarm_f && cfg.calendar_clock_enable;
    events.dwdt     = dwdt_f;
    events.int0     = int0_wake;
    events.por      = por_f;
    events.brownout = bor_f && state_q == ST_DEEP;
  end
  assign ds_wake = events.mclear || events.alarm || events.dwdt ||
                   events.int0 || events.por;

  always_comb begin
    state_d     = state_q;
    ds_en_d     = ds_en_q;
    release_d   = release_q;
    bor_flag_d  = bor_flag_q;
    exit_flag_d = exit_flag_q;
    ret_en_d    = ret_en_q;
    wake_d      = wake_q;
    scratch0_d  = scratch0_q;
    scratch1_d  = scratch1_q;
    pend_d      = wr ? prot_hit && !commit : pend_q;
    pend_addr_d = wr ? addr : pend_addr_q;
    pend_data_d = wr ? wdata : pend_data_q;
    win_d       = win_q;
    hold_d      = hold_q;
    cnt_d       = cnt_q;
    settle_d    = settle_q;
    int0_arm_d  = int0_arm_q;
    int0_ref_d  = int0_ref_q;
    src_d       = src_q;
    pul_d       = '0;
    rdata_d     = '0;

    // software side of the register file
    if (wr && addr == `OFF_RESET_CONTROL) begin
      ret_en_d = wdata[`BIT_RETENTION_EN];
      if (!wdata[`BIT_DS_EXIT_FLAG]) begin
        exit_flag_d = 1'b0;
      end
    end
    if (commit) begin
      case (addr)
        `OFF_DS_CONTROL: begin
          if (wdata[`BIT_DS_ENABLE] && hold_q == 2'd0) begin
            ds_en_d = 1'b1;
            win_d  = 3'd0;
            wake_d = '0;
          end else if (!wdata[`BIT_DS_ENABLE]) begin
            ds_en_d = 1'b0;
          end
          if (!wdata[`BIT_DS_BROWNOUT]) begin
            bor_flag_d = 1'b0;
          end
          if (!wdata[`BIT_DS_RELEASE] && release_q) begin
            release_d = 1'b0;
            hold_d    = REENTRY;
          end
        end
        `OFF_WAKE_SOURCE: wake_d     = wdata[5:0];
        `OFF_SCRATCH_0:   scratch0_d = wdata;
        `OFF_SCRATCH_1:   scratch1_d = wdata;
        default:          wake_d     = wake_d;
      endcase
    end

    // re-entry hold-off and the enable window, counted in instructions
    if (instr_cycle && hold_q != 2'd0) begin
      hold_d = hold_q - 2'd1;
    end
    if (ds_en_q && instr_cycle && !deep_go && !commit) begin
      if (win_q == ENTRY_LAST) begin
        ds_en_d = 1'b0;
      end else begin
        win_d = win_q + 3'd1;
      end
    end

    // hardware sets win over software clears
    if (ds_en_q || release_q) begin
      wake_d = wake_d | events;
    end

    case (state_q)
      ST_RUN: begin
        if (psave_valid && psave_idle) begin
          state_d         = ST_IDLE;
          pul_d.wdt_clear = 1'b1;
        end else if (deep_go) begin
          state_d           = ST_DEEP;
          release_d         = 1'b1;
          exit_flag_d       = 1'b1;
          int0_arm_d        = cfg.int0_enable;
          int0_ref_d        = int0_f;
          pul_d.dwdt_reset  = 1'b1;
          pul_d.irq_discard = 1'b1;
          pul_d.wdt_clear   = cfg.wdt_enable;
        end else if (psave_valid) begin
          state_d         = ST_SLEEP;
          src_d           = clk_src;
          settle_d        = !cfg.low_power_config_fuse && ret_en_q;
          pul_d.wdt_clear = cfg.wdt_enable;
        end
      end
      ST_IDLE: begin
        if (wake_any) begin
          state_d = ST_RUN;
        end
      end
      ST_SLEEP: begin
        if (wake_any) begin
          cnt_d   = 16'd0;
          state_d = settle_q ? ST_SETTLE : ST_RUN;
        end
      end
      ST_SETTLE: begin
        if (cnt_q == SETTLE_LAST) begin
          state_d = ST_RUN;
        end else begin
          cnt_d = cnt_q + 16'd1;
        end
      end
      ST_DEEP: begin
        if (events.brownout) begin
          bor_flag_d = 1'b1;
        end
        if (ds_wake) begin
          state_d    = ST_EXIT;
          cnt_d      = 16'd0;
          ds_en_d    = 1'b0;
          int0_arm_d = 1'b0;
        end
      end
      ST_EXIT: begin
        if (cnt_q == EXIT_LAST) begin
          state_d = ST_RUN;
        end else begin
          cnt_d = cnt_q + 16'd1;
        end
      end
      default: state_d = ST_RUN;
    endcase
    pul_d.core_reset = state_d == ST_EXIT;

    // gating follows the next state so it lands with the mode
    ctl_d = '0;
    case (state_d)
      ST_RUN: begin
        ctl_d.cpu_clk_en       = 1'b1;
        ctl_d.sys_clk_en       = 1'b1;
        ctl_d.osc_en           = 1'b1;
        ctl_d.periph_sysclk_en = 1'b1;
        ctl_d.cmon_en          = cfg.cmon_enable;
        ctl_d.lposc_en         = cfg.wdt_enable || cfg.cmon_enable;
      end
      ST_IDLE: begin
        ctl_d.sys_clk_en       = 1'b1;
        ctl_d.osc_en           = 1'b1;
        ctl_d.periph_sysclk_en = 1'b1;
        ctl_d.cmon_en          = cfg.cmon_enable;
        ctl_d.lposc_en         = cfg.wdt_enable || cfg.cmon_enable;
      end
      ST_SLEEP, ST_SETTLE, ST_DEEP: begin
        ctl_d.pins_frozen = 1'b1;
        ctl_d.lposc_en    = cfg.wdt_enable ||
                            (cfg.calendar_clock_enable &&
                             cfg.calendar_on_lposc);
        ctl_d.retention_reg_en = state_d == ST_SLEEP &&
                                 settle_d;
      end
      ST_EXIT: begin
        ctl_d.pins_frozen = 1'b1;
      end
      default: ctl_d = '0;
    endcase
    if (release_d) begin
      ctl_d.pins_frozen = 1'b1;
    end

    if (rd) begin
      case (addr)
        `OFF_DS_CONTROL: begin
          rdata_d[`BIT_DS_ENABLE]   = ds_en_q;
          rdata_d[`BIT_DS_BROWNOUT] = bor_flag_q;
          rdata_d[`BIT_DS_RELEASE]  = release_q;
        end
        `OFF_WAKE_SOURCE: rdata_d[5:0] = wake_q;
        `OFF_SCRATCH_0:   rdata_d      = scratch0_q;
        `OFF_SCRATCH_1:   rdata_d      = scratch1_q;
        `OFF_RESET_CONTROL: begin
          rdata_d[`BIT_RETENTION_EN] = ret_en_q;
          rdata_d[`BIT_DS_EXIT_FLAG] = exit_flag_q;
        end
        `OFF_STATUS:      rdata_d[4:0] = {hold_q != 2'd0, pend_q, state_q};
        default:          rdata_d      = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q     <= ST_RUN;
      ds_en_q     <= 1'b0;
      release_q   <= 1'b0;
      bor_flag_q  <= 1'b0;
      exit_flag_q <= 1'b0;
      ret_en_q    <= 1'b0;
      wake_q      <= '0;
      scratch0_q  <= `RESET_VAL_16;
      scratch1_q  <= `RESET_VAL_16;
      pend_q      <= 1'b0;
      pend_addr_q <= '0;
      pend_data_q <= `RESET_VAL_16;
      win_q       <= 3'd0;
      hold_q      <= 2'd0;
      cnt_q       <= 16'd0;
      settle_q    <= 1'b0;
      int0_arm_q  <= 1'b0;
      int0_ref_q  <= 1'b0;
      src_q       <= 2'd0;
      ctl_q       <= 8'hE4;
      pul_q       <= '0;
      rdata_q     <= `RESET_VAL_16;
    end else begin
      state_q     <= state_d;
      ds_en_q     <= ds_en_d;
      release_q   <= release_d;
      bor_flag_q  <= bor_flag_d;
      exit_flag_q <= exit_flag_d;
      ret_en_q    <= ret_en_d;
      wake_q      <= wake_d;
      scratch0_q  <= scratch0_d;
      scratch1_q  <= scratch1_d;
      pend_q      <= pend_d;
      pend_addr_q <= pend_addr_d;
      pend_data_q <= pend_data_d;
      win_q       <= win_d;
      hold_q      <= hold_d;
      cnt_q       <= cnt_d;
      settle_q    <= settle_d;
      int0_arm_q  <= int0_arm_d;
      int0_ref_q  <= int0_ref_d;
      src_q       <= src_d;
      ctl_q       <= ctl_d;
      pul_q       <= pul_d;
      rdata_q     <= rdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs

  assign rdata          = rdata_q;
  assign clk_ctrl       = ctl_q;
  assign pulses         = pul_q;
  assign resume_clk_src = src_q;
  assign state          = state_q;

endmodule

`default_nettype wire

// *** dv/psm_checker_sva.sv ***
/*
  Concurrent checks on the power-save mode controller top ports.
  Assumes one clock, a synchronous active-low reset, registered outputs.
*/
`timescale 1ns/1ns
`default_nettype none

module psm_checker #(
  parameter int SETTLE_CYC = 2,
  parameter int EXIT_CYC   = 2
) (
  input wire logic                       sys_clk,            // clock
  input wire logic                       rst_n,              // reset, low
  input wire logic                       psave_valid,        // instruction
  input wire logic                       psave_idle,         // idle select
  input wire logic [1:0]                 clk_src,            // source
  input wire power_save_pkg::pwr_cfg_s   cfg,                // enables
  input wire logic                       irq_wake,           // irq wake
  input wire logic                       reset_req,          // reset wake
  input wire logic                       wdt_timeout,        // wdt wake
  input wire logic                       master_clear_pin_n, // pin, low
  input wire power_save_pkg::clk_ctrl_s  clk_ctrl,           // gating
  input wire power_save_pkg::pwr_pulse_s pulses,             // pulses
  input wire logic [1:0]                 resume_clk_src,     // restart src
  input wire power_save_pkg::pwr_state_e state               // mode
);
  import power_save_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////
  // cycles already spent in the present state, for timed states
  pwr_state_e  prev_q;
  int unsigned cnt_q;
  int unsigned cnt_d;
  always_comb cnt_d = (state == prev_q) ? cnt_q + 1 : 0;
  always_ff @(posedge sys_clk) begin
    prev_q <= rst_n ? state : ST_RUN;
    cnt_q  <= rst_n ? cnt_d : 0;
  end

  ////////////////////////////////////////////////////////////////////////
  a_idle_entry: assert property (state == ST_RUN && psave_valid &&
    psave_idle |=> state == ST_IDLE && pulses.wdt_clear &&
    clk_ctrl.sys_clk_en && !clk_ctrl.cpu_clk_en) else $error("idle entry");
  a_idle_wake: assert property (state == ST_IDLE && (irq_wake ||
    reset_req || wdt_timeout) |=> state == ST_RUN && clk_ctrl.cpu_clk_en)
    else $error("idle wake");
  a_sleep_gates: assert property (state == ST_SLEEP |->
    !(clk_ctrl.sys_clk_en | clk_ctrl.osc_en | clk_ctrl.cmon_en |
    clk_ctrl.periph_sysclk_en) && clk_ctrl.pins_frozen)
    else $error("sleep gating");
  a_lposc_kept: assert property (state == ST_SLEEP && $stable(cfg) |->
    clk_ctrl.lposc_en == (cfg.wdt_enable ||
    cfg.calendar_clock_enable && cfg.calendar_on_lposc))
    else $error("lposc enable");
  a_wdt_cleared: assert property (state == ST_RUN && psave_valid &&
    !psave_idle && cfg.wdt_enable |=> pulses.wdt_clear)
    else $error("wdt not cleared");
  a_resume_source: assert property (state == ST_RUN && psave_valid &&
    !psave_idle |=> state != ST_SLEEP || resume_clk_src == $past(clk_src))
    else $error("resume source");
  a_retention_gate: assert property (clk_ctrl.retention_reg_en |->
    state == ST_SLEEP && !cfg.low_power_config_fuse)
    else $error("retention enable");
  a_settle_time: assert property (prev_q == ST_SETTLE &&
    state != ST_SETTLE |-> cnt_q == SETTLE_CYC - 1) else $error("settle");
  a_deep_entry: assert property ($rose(state == ST_DEEP) |->
    pulses.dwdt_reset && pulses.irq_discard && !clk_ctrl.sys_clk_en &&
    !clk_ctrl.periph_sysclk_en && clk_ctrl.pins_frozen)
    else $error("deep entry");
  a_mclear_exit: assert property (state == ST_DEEP &&
    $fell(master_clear_pin_n) |-> ##[1:6] state == ST_EXIT)
    else $error("mclear exit");
  a_exit_reset: assert property (state == ST_EXIT |->
    pulses.core_reset && cnt_d < EXIT_CYC) else $error("exit reset");
endmodule

bind power_save_mode_controller psm_checker #(
  .SETTLE_CYC(SETTLE_CYC),
  .EXIT_CYC  (EXIT_CYC)
) chk (.sys_clk, .rst_n, .psave_valid, .psave_idle, .clk_src, .cfg,
  .irq_wake, .reset_req, .wdt_timeout, .master_clear_pin_n, .clk_ctrl,
  .pulses, .resume_clk_src, .state);

`default_nettype wire

// *** dv/psm_partner.sv ***
/*
  Firmware and wake-pin model: instruction strobes, power-save entry,
  external wake pins. Assumes the bench calls its tasks hierarchically.
*/
`timescale 1ns/1ns
`default_nettype none

module psm_partner (
  input  wire logic sys_clk,            // clock
  input  wire logic rst_n,              // reset, low
  output logic      instr_cycle,        // every other clock
  output logic      psave_valid,        // power-save instruction
  output logic      psave_idle,         // 1 idle, 0 sleep
  output logic      ext_int0,           // interrupt 0 pin
  output logic      master_clear_pin_n, // pulled up
  output logic      calendar_alarm,     // alarm
  output logic      dwdt_timeout        // deep watchdog
);
  initial begin
    {psave_valid, psave_idle, ext_int0} = 3'b000;
    {calendar_alarm, dwdt_timeout} = 2'b00;
    master_clear_pin_n = 1'b1;
  end

  always_ff @(posedge sys_clk) instr_cycle <= rst_n ? !instr_cycle : 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // three no-ops, then the instruction on the next strobe
  task automatic power_save(input logic idle);
    int n;
    n = 0;
    while (n < 3) begin
      @(posedge sys_clk);
      n += int'(instr_cycle);
    end
    @(posedge sys_clk);
    psave_valid <= 1'b1;
    psave_idle  <= idle;
    @(posedge sys_clk);
    psave_valid <= 1'b0;
  endtask

  // int0 rests low at entry, so driving it high is a real change
  task automatic pin_event(input int i, input logic on);
    @(posedge sys_clk);
    case (i)
      0: master_clear_pin_n <= !on;
      1: calendar_alarm <= on;
      2: dwdt_timeout <= on;
      default: ext_int0 <= on;
    endcase
  endtask

  task automatic hold_off();
    repeat (8) @(posedge sys_clk);
  endtask
endmodule

`default_nettype wire

// *** dv/power_save_mode_controller_bench.sv ***
/*
  Self-checking bench of the power-save mode controller.
  Assumes the checker bind and the partner model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module power_save_mode_controller_bench;
  import power_save_pkg::*;
  localparam int SETTLE = 2;
  logic       sys_clk     = 1'b0;
  logic       rst_n       = 1'b0;
  logic [7:0] addr        = 8'h00;
  logic [15:0] wdata      = 16'h0000;
  logic       wr          = 1'b0;
  logic       rd          = 1'b0;
  logic [1:0] clk_src     = 2'h0;
  pwr_cfg_s   cfg         = 7'h40;
  logic [2:0] wake        = 3'h0;
  logic [15:0] rdata, s0, d;
  logic [1:0] resume_clk_src;
  logic       instr_cycle, psave_valid, psave_idle, ext_int0;
  logic       master_clear_pin_n, calendar_alarm, dwdt_timeout;
  clk_ctrl_s  clk_ctrl;
  pwr_pulse_s pulses;
  pwr_state_e state;
  int         n_errors = 0;
  int         n_tests  = 0;
  int         seed     = 32'h81f9;

  always #10 sys_clk = ~sys_clk;

  power_save_mode_controller #(.SETTLE_CYC(SETTLE), .EXIT_CYC(2)) dut (
    .sys_clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .instr_cycle,
    .psave_valid, .psave_idle, .clk_src, .cfg, .irq_wake(wake[0]),
    .reset_req(wake[1]), .wdt_timeout(wake[2]), .ext_int0,
    .master_clear_pin_n, .por_event(1'b0), .brownout_event(1'b0),
    .dwdt_timeout, .calendar_alarm, .clk_ctrl, .pulses, .resume_clk_src,
    .state);
  psm_partner fw (.sys_clk, .rst_n, .instr_cycle, .psave_valid,
    .psave_idle, .ext_int0, .master_clear_pin_n, .calendar_alarm,
    .dwdt_timeout);

  ////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
  endtask

  task automatic wr2(input logic [7:0] a, input logic [15:0] v);
    wr_reg(a, v);
    wr_reg(a, v);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
    #1 check(rdata, v, "read");
  endtask

  task automatic wait_state(input pwr_state_e s);
    #1;
    for (int i = 0; i < 60 && state !== s; i++) @(posedge sys_clk) #1;
    check(16'(state), 16'(s), "state");
    if (state !== s) finish_test();
  endtask

  function automatic logic lposc_need(input pwr_cfg_s c);
    return c.wdt_enable | (c.calendar_clock_enable & c.calendar_on_lposc);
  endfunction

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    s0 = 16'h0000;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk) #1 check(16'(clk_ctrl), 16'h00E4, "reset gating");
    for (int a = 0; a <= 8'h20; a += 4) rd_chk(8'(a), 16'h0000);
    for (int k = 0; k < 4; k++) begin
      d = 16'($random(seed));
      wr_reg(8'h08, d);
      wr_reg(8'h0C, ~d);
      wr_reg(8'h08, d);
      rd_chk(8'h08, s0);
      wr2(8'h08, d);
      s0 = d;
      rd_chk(8'h08, s0);
    end
    $display("protected writes done");
    for (int i = 0; i < 6; i++) begin
      cfg     <= 7'($random(seed)) | 7'h40;
      clk_src <= 2'($random(seed));
      fw.power_save(i < 3);
      wait_state(i < 3 ? ST_IDLE : ST_SLEEP);
      if (i >= 3) begin
        check(16'(resume_clk_src), 16'(clk_src), "resume");
        check(16'(clk_ctrl.lposc_en), 16'(lposc_need(cfg)), "lposc");
      end
      wake <= 3'(1 << (i % 3));
      wait_state(ST_RUN);
      wake <= 3'h0;
    end
    $display("idle and sleep done");
    cfg <= 7'h00;
    wr_reg(8'h10, 16'h1000);
    fw.power_save(1'b0);
    wait_state(ST_SLEEP);
    check(16'(clk_ctrl.retention_reg_en), 16'h0001, "retention");
    wake <= 3'h1;
    wait_state(ST_SETTLE);
    wake <= 3'h0;
    repeat (SETTLE - 1) @(posedge sys_clk) #1 check(16'(state), 16'(ST_SETTLE), "settle");
    @(posedge sys_clk) #1 check(16'(state), 16'(ST_RUN), "settle end");
    wr_reg(8'h10, 16'h0000);
    cfg <= 7'h4B;
    $display("retention sleep done");
    for (int i = 0; i < 4; i++) begin
      wr2(8'h00, 16'h8000);
      fw.power_save(1'b0);
      wait_state(ST_DEEP);
      fw.pin_event(i, 1'b1);
      wait_state(ST_EXIT);
      fw.pin_event(i, 1'b0);
      wait_state(ST_RUN);
      rd_chk(8'h00, 16'h0001);
      rd_chk(8'h04, 16'(1 << i));
      rd_chk(8'h10, 16'h0400);
      rd_chk(8'h08, s0);
      check(16'(clk_ctrl.pins_frozen), 16'h0001, "frozen");
      wr2(8'h00, 16'h0000);
      repeat (2) @(posedge sys_clk);
      #1 check(16'(clk_ctrl.pins_frozen), 16'h0000, "released");
      wr_reg(8'h10, 16'h0000);
      fw.hold_off();
    end
    $display("deep sleep done");
    wr2(8'h00, 16'h8000);
    rd_chk(8'h04, 16'h0000);
    repeat (12) @(posedge sys_clk);
    rd_chk(8'h00, 16'h0000);
    $display("enable lapse done");
    finish_test();
  end
endmodule

`default_nettype wire
